// ### src/adc_clk_div.sv
// Purpose: divides the chosen ADC source clock by 1, 2, 4 or 8
// Assumes: source is a clean level sampled on clk
// Notes: output is a registered level; gated output sits low

`timescale 1ns/1ns

// ==================================================
// module
module adc_clk_div (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic [1:0] div_sel,
  input wire logic gate_off,
  // source
  input wire logic src_level,
  // result
  output logic adc_clk
);

  logic src_prev;
  logic [2:0] edge_cnt;
  logic next_src_prev;
  logic [2:0] next_edge_cnt;
  logic next_adc_clk;

  always_comb begin
    next_src_prev = src_level;
    next_edge_cnt = edge_cnt;
    if (src_level && !src_prev) begin
      next_edge_cnt = edge_cnt + 3'h1;
    end
    unique case (div_sel)
      ctl_top_pkg::adc_div_by_one: next_adc_clk = src_level;
      ctl_top_pkg::adc_div_by_two: next_adc_clk = next_edge_cnt[0];
      ctl_top_pkg::adc_div_by_four: next_adc_clk = next_edge_cnt[1];
      ctl_top_pkg::adc_div_by_eight: next_adc_clk = next_edge_cnt[2];
    endcase
    if (gate_off) begin
      next_adc_clk = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_prev <= 1'b0;
      edge_cnt <= 3'h0;
      adc_clk <= 1'b0;
    end else begin
      src_prev <= next_src_prev;
      edge_cnt <= next_edge_cnt;
      adc_clk <= next_adc_clk;
    end
  end

endmodule : adc_clk_div

// ### src/clock_reset_control_top.sv
// Purpose: control-top registers for clocks, PLL rate, soft resets, analog power
// Assumes: byte stream from the serial slave front end on the system clock
// Notes: registers 0x08, 0x09 and 0x0B written on the register address after the arm command; 0x0A reads as zero

`timescale 1ns/1ns

// ==================================================
// Functional notes
// - Register writes are accepted only after the non-USB register command byte on the command address.
// - The four registers sit at register addresses 0x08, 0x09, 0x0A and 0x0B.
// - Clock register bit 7 picks the ADC clock from the ADC when one and from the PLL when zero.
// - Clock register bits 6..5 divide the ADC clock by 1, 2, 4 or 8.
// - Clock register bits 3, 2 and 1 stop the 48 MHz, receiver and ADC clocks when one.
// - Reset/PLL register bits 7..6 pick 256 times 44.1, 32, 48 or 44.1 kHz for the PLL.
// - Reset/PLL register bit 3 holds the USB protocol block in reset while one.
// - Reset/PLL register bit 1 holds the digital audio block in reset while one.
// - Reset/PLL register bit 0 holds the gain control logic in reset while one.
module clock_reset_control_top (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // byte channel from the serial slave
  input wire logic xfer_start,
  input wire logic byte_valid,
  input wire logic byte_on_reg_addr,
  input wire logic [7:0] byte_data,
  input wire logic rd_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  // clock sources from pins
  input wire logic adc_src_clk,
  input wire logic pll_src_clk,
  // clock control
  output logic adc_clk,
  output logic clk48_run,
  output logic rec_clk_run,
  output logic [1:0] pll_rate_sel,
  // block resets
  output logic usb_protocol_block_rst,
  output logic audio_if_rst,
  output logic gain_control_soft_reset,
  // analog power downs
  output logic pll_pwr_off,
  output logic adc_l_pwr_off,
  output logic adc_r_pwr_off,
  output logic agc_l_pwr_off,
  output logic agc_r_pwr_off,
  // status
  output logic regs_armed
);

  // ==================================================
  // state
  logic [7:0] clock_source_and_gating;
  logic [7:0] reset_and_pll_select;
  logic [7:0] analog_power_control;
  logic armed;
  logic addr_loaded;
  logic [7:0] reg_ptr;

  logic [7:0] next_clock_source_and_gating;
  logic [7:0] next_reset_and_pll_select;
  logic [7:0] next_analog_power_control;
  logic next_armed;
  logic next_addr_loaded;
  logic [7:0] next_reg_ptr;
  logic [7:0] next_rd_data;
  logic next_rd_valid;
  logic [7:0] rd_mux;
  logic cmd_byte;
  logic addr_byte;
  logic data_byte;
  logic read_take;
  logic wr_clock;
  logic wr_reset;
  logic wr_power;

  // ==================================================
  // byte classification and write strobes
  always_comb begin
    cmd_byte = byte_valid && !byte_on_reg_addr;
    // first byte of a transfer, or first after a command, is the address
    addr_byte = byte_valid && byte_on_reg_addr && armed && (!addr_loaded || xfer_start);
    data_byte = byte_valid && byte_on_reg_addr && armed && addr_loaded && !xfer_start;
    // a read waits for a cycle with no byte
    read_take = rd_req && armed && addr_loaded && !byte_valid;
    // no strobe for the multiplexer register
    wr_clock = data_byte && (reg_ptr == ctl_top_pkg::OFS_CLOCK_SOURCE_AND_GATING);
    wr_reset = data_byte && (reg_ptr == ctl_top_pkg::OFS_RESET_AND_PLL_SELECT);
    wr_power = data_byte && (reg_ptr == ctl_top_pkg::OFS_ANALOG_POWER_CONTROL);
  end

  // ==================================================
  // register read mux
  always_comb begin
    unique case (reg_ptr)
      ctl_top_pkg::OFS_CLOCK_SOURCE_AND_GATING: rd_mux = clock_source_and_gating;
      ctl_top_pkg::OFS_RESET_AND_PLL_SELECT: rd_mux = reset_and_pll_select;
      ctl_top_pkg::OFS_IO_MULTIPLEXER_CONTROL: rd_mux = 8'h00;
      ctl_top_pkg::OFS_ANALOG_POWER_CONTROL: rd_mux = analog_power_control;
      default: rd_mux = 8'h00;
    endcase
  end

  // ==================================================
  // command tracking and register writes
  always_comb begin
    next_clock_source_and_gating = clock_source_and_gating;
    next_reset_and_pll_select = reset_and_pll_select;
    next_analog_power_control = analog_power_control;
    next_armed = armed;
    next_addr_loaded = addr_loaded;
    next_reg_ptr = reg_ptr;
    if (xfer_start) begin
      next_addr_loaded = 1'b0;
    end
    if (cmd_byte) begin
      // any other command disarms the register path
      next_armed = (byte_data == ctl_top_pkg::CMD_NON_USB_REG);
      next_addr_loaded = 1'b0;
    end
    if (addr_byte) begin
      next_reg_ptr = byte_data;
      next_addr_loaded = 1'b1;
    end
    if (wr_clock) begin
      next_clock_source_and_gating =
        byte_data & ctl_top_pkg::MSK_CLOCK_SOURCE_AND_GATING;
    end
    if (wr_reset) begin
      next_reset_and_pll_select =
        byte_data & ctl_top_pkg::MSK_RESET_AND_PLL_SELECT;
    end
    if (wr_power) begin
      next_analog_power_control =
        byte_data & ctl_top_pkg::MSK_ANALOG_POWER_CONTROL;
    end
    // ignored addresses still move the pointer, as reads do
    if (data_byte || read_take) begin
      next_reg_ptr = reg_ptr + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clock_source_and_gating <= ctl_top_pkg::RST_CLOCK_SOURCE_AND_GATING;
      reset_and_pll_select <= ctl_top_pkg::RST_RESET_AND_PLL_SELECT;
      analog_power_control <= ctl_top_pkg::RST_ANALOG_POWER_CONTROL;
      armed <= 1'b0;
      addr_loaded <= 1'b0;
      reg_ptr <= 8'h00;
    end else begin
      clock_source_and_gating <= next_clock_source_and_gating;
      reset_and_pll_select <= next_reset_and_pll_select;
      analog_power_control <= next_analog_power_control;
      armed <= next_armed;
      addr_loaded <= next_addr_loaded;
      reg_ptr <= next_reg_ptr;
    end
  end

  // ==================================================
  // read data
  always_comb begin
    next_rd_data = rd_data;
    next_rd_valid = read_take;
    if (read_take) begin
      next_rd_data = rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // ==================================================
  // source synchronisers
  // both sources are resampled so the divider sees clean levels only
  logic adc_src_level;
  logic pll_src_level;
  logic adc_sel_level;

  pin_sync u_sync_adc (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(adc_src_clk),
    .level(adc_src_level)
  );

  pin_sync u_sync_pll (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(pll_src_clk),
    .level(pll_src_level)
  );

  // ==================================================
  // source select and divider
  always_comb begin
    adc_sel_level = clock_source_and_gating[ctl_top_pkg::BIT_ADC_SRC_SEL] ?
      adc_src_level : pll_src_level;
  end

  adc_clk_div u_adc_div (
    .clk(clk),
    .sys_rst(sys_rst),
    .div_sel(clock_source_and_gating[ctl_top_pkg::BIT_ADC_DIV_HI:
      ctl_top_pkg::BIT_ADC_DIV_LO]),
    .gate_off(clock_source_and_gating[ctl_top_pkg::BIT_GATE_ADC]),
    .src_level(adc_sel_level),
    .adc_clk(adc_clk)
  );

  // ==================================================
  // registered control outputs
  logic next_clk48_run;
  logic next_rec_clk_run;
  logic [1:0] next_pll_rate_sel;
  logic next_usb_protocol_block_rst;
  logic next_audio_if_rst;
  logic next_gain_control_soft_reset;
  logic next_regs_armed;
  logic [1:0] freq_code;

  // outputs follow their register one cycle later
  always_comb begin
    freq_code = reset_and_pll_select[ctl_top_pkg::BIT_SYNTH_FREQ_HI:
      ctl_top_pkg::BIT_SYNTH_FREQ_LO];
    next_clk48_run = !clock_source_and_gating[ctl_top_pkg::BIT_GATE_CLK48];
    next_rec_clk_run = !clock_source_and_gating[ctl_top_pkg::BIT_GATE_REC];
    next_usb_protocol_block_rst = reset_and_pll_select[ctl_top_pkg::BIT_RST_USB];
    next_audio_if_rst = reset_and_pll_select[ctl_top_pkg::BIT_RST_AUDIO];
    next_gain_control_soft_reset = reset_and_pll_select[ctl_top_pkg::BIT_RST_GAIN];
    next_regs_armed = armed;
    // code three is a second 44.1 kHz setting
    unique case (freq_code)
      ctl_top_pkg::synth_freq_code_zero: next_pll_rate_sel = ctl_top_pkg::rate_44k1;
      ctl_top_pkg::synth_freq_code_one: next_pll_rate_sel = ctl_top_pkg::rate_32k;
      ctl_top_pkg::synth_freq_code_two: next_pll_rate_sel = ctl_top_pkg::rate_48k;
      ctl_top_pkg::synth_freq_code_three: next_pll_rate_sel = ctl_top_pkg::rate_44k1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clk48_run <= 1'b1;
      rec_clk_run <= 1'b1;
      pll_rate_sel <= ctl_top_pkg::rate_44k1;
      usb_protocol_block_rst <= 1'b0;
      audio_if_rst <= 1'b0;
      gain_control_soft_reset <= 1'b0;
      regs_armed <= 1'b0;
    end else begin
      clk48_run <= next_clk48_run;
      rec_clk_run <= next_rec_clk_run;
      pll_rate_sel <= next_pll_rate_sel;
      usb_protocol_block_rst <= next_usb_protocol_block_rst;
      audio_if_rst <= next_audio_if_rst;
      gain_control_soft_reset <= next_gain_control_soft_reset;
      regs_armed <= next_regs_armed;
    end
  end

  // ==================================================
  // analog power-down outputs
  logic next_pll_pwr_off;
  logic next_adc_l_pwr_off;
  logic next_adc_r_pwr_off;
  logic next_agc_l_pwr_off;
  logic next_agc_r_pwr_off;

  always_comb begin
    next_pll_pwr_off = analog_power_control[ctl_top_pkg::BIT_PWR_PLL_OFF];
    next_adc_l_pwr_off = analog_power_control[ctl_top_pkg::BIT_PWR_ADC_L_OFF];
    next_adc_r_pwr_off = analog_power_control[ctl_top_pkg::BIT_PWR_ADC_R_OFF];
    next_agc_l_pwr_off = analog_power_control[ctl_top_pkg::BIT_PWR_AGC_L_OFF];
    next_agc_r_pwr_off = analog_power_control[ctl_top_pkg::BIT_PWR_AGC_R_OFF];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pll_pwr_off <= 1'b0;
      adc_l_pwr_off <= 1'b0;
      adc_r_pwr_off <= 1'b0;
      agc_l_pwr_off <= 1'b0;
      agc_r_pwr_off <= 1'b0;
    end else begin
      pll_pwr_off <= next_pll_pwr_off;
      adc_l_pwr_off <= next_adc_l_pwr_off;
      adc_r_pwr_off <= next_adc_r_pwr_off;
      agc_l_pwr_off <= next_agc_l_pwr_off;
      agc_r_pwr_off <= next_agc_r_pwr_off;
    end
  end

endmodule : clock_reset_control_top

// ### src/ctl_top_pkg.sv
// Purpose: shared constants for the control-top register group
// Assumes: byte-wide registers reached through the serial command channel
// Notes: offsets are register addresses on the second bus address

// ==================================================
// package
package ctl_top_pkg;

  // command channel
  localparam logic [7:0] CMD_NON_USB_REG = 8'hE8;

  // register addresses
  localparam logic [7:0] OFS_CLOCK_SOURCE_AND_GATING = 8'h08;
  localparam logic [7:0] OFS_RESET_AND_PLL_SELECT = 8'h09;
  localparam logic [7:0] OFS_IO_MULTIPLEXER_CONTROL = 8'h0A;
  localparam logic [7:0] OFS_ANALOG_POWER_CONTROL = 8'h0B;

  // values after reset
  localparam logic [7:0] RST_CLOCK_SOURCE_AND_GATING = 8'h00;
  localparam logic [7:0] RST_RESET_AND_PLL_SELECT = 8'h00;
  localparam logic [7:0] RST_ANALOG_POWER_CONTROL = 8'h00;

  // writable bits; others read as zero
  localparam logic [7:0] MSK_CLOCK_SOURCE_AND_GATING = 8'hEE;
  localparam logic [7:0] MSK_RESET_AND_PLL_SELECT = 8'hCB;
  localparam logic [7:0] MSK_ANALOG_POWER_CONTROL = 8'h2F;

  // clock_source_and_gating fields
  localparam int BIT_ADC_SRC_SEL = 7;
  localparam int BIT_ADC_DIV_HI = 6;
  localparam int BIT_ADC_DIV_LO = 5;
  localparam int BIT_GATE_CLK48 = 3;
  localparam int BIT_GATE_REC = 2;
  localparam int BIT_GATE_ADC = 1;

  // reset_and_pll_select fields
  localparam int BIT_SYNTH_FREQ_HI = 7;
  localparam int BIT_SYNTH_FREQ_LO = 6;
  localparam int BIT_RST_USB = 3;
  localparam int BIT_RST_AUDIO = 1;
  localparam int BIT_RST_GAIN = 0;

  // analog_power_control fields
  localparam int BIT_PWR_PLL_OFF = 5;
  localparam int BIT_PWR_ADC_L_OFF = 3;
  localparam int BIT_PWR_ADC_R_OFF = 2;
  localparam int BIT_PWR_AGC_L_OFF = 1;
  localparam int BIT_PWR_AGC_R_OFF = 0;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    adc_div_by_one = 2'h0,
    adc_div_by_two = 2'h1,
    adc_div_by_four = 2'h2,
    adc_div_by_eight = 2'h3
  } adc_div_t;

  typedef enum logic [1:0] {
    synth_freq_code_zero = 2'h0,
    synth_freq_code_one = 2'h1,
    synth_freq_code_two = 2'h2,
    synth_freq_code_three = 2'h3
  } synth_freq_t;

  // decoded sample rate for the PLL: 256 x rate
  typedef enum logic [1:0] {
    rate_44k1 = 2'h0,
    rate_32k = 2'h1,
    rate_48k = 2'h2
  } sample_rate_t;

endpackage : ctl_top_pkg

// ### src/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: a change counts once stages two and three agree

`timescale 1ns/1ns

// ==================================================
// module
module pin_sync (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // pin side
  input wire logic pin_in,
  // clean side
  output logic level
);

  logic [ctl_top_pkg::SYNC_STAGES-1:0] stage;
  logic [ctl_top_pkg::SYNC_STAGES-1:0] next_stage;
  logic next_level;

  always_comb begin
    next_stage = {stage[ctl_top_pkg::SYNC_STAGES-2:0], pin_in};
    // first stage feeds only the second
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stage <= '0;
      level <= 1'b0;
    end else begin
      stage <= next_stage;
      level <= next_level;
    end
  end

endmodule : pin_sync

// ### tb/ctl_top_asserts.sv
// Purpose: port checks for the control-top block
// Assumes: one clock, sync active-high reset
// Notes: attached by the bind below
`timescale 1ns/1ns
// ==================================================
// checker
module ctl_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // byte channel
  input wire logic byte_valid,
  input wire logic byte_on_reg_addr,
  input wire logic [7:0] byte_data,
  input wire logic rd_req,
  input wire logic rd_valid,
  // controls
  input wire logic clk48_run,
  input wire logic rec_clk_run,
  input wire logic [1:0] pll_rate_sel,
  input wire logic usb_protocol_block_rst,
  input wire logic audio_if_rst,
  input wire logic gain_control_soft_reset,
  input wire logic regs_armed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wire logic cmd_b = byte_valid && !byte_on_reg_addr;
  wire logic wr_b = byte_valid && byte_on_reg_addr;
  wire logic [6:0] outs = {clk48_run, rec_clk_run, pll_rate_sel, usb_protocol_block_rst,
    audio_if_rst, gain_control_soft_reset};
  sequence s_arm;
    cmd_b && byte_data == ctl_top_pkg::CMD_NON_USB_REG ##1 !cmd_b;
  endsequence
  sequence s_disarm;
    cmd_b && byte_data != ctl_top_pkg::CMD_NON_USB_REG ##1 !cmd_b;
  endsequence
  a_arm_cmd: assert property (s_arm |=> regs_armed)
    else $error("not armed after arm command");
  a_disarm_cmd: assert property (s_disarm |=> !regs_armed)
    else $error("still armed after other command");
  a_out_cause: assert property ($changed(outs) |->
    $past(wr_b, 2) || $past(sys_rst) || $past(sys_rst, 2))
    else $error("control output changed without a write");
  a_rate_legal: assert property (pll_rate_sel != 2'h3)
    else $error("rate select shows code three");
  a_usb_rst_src: assert property ($rose(usb_protocol_block_rst) |->
    $past(wr_b, 2) && $past(byte_data[3], 2))
    else $error("usb reset rose without bit 3");
  a_audio_rst_src: assert property ($rose(audio_if_rst) |->
    $past(wr_b, 2) && $past(byte_data[1], 2))
    else $error("audio reset rose without bit 1");
  a_gain_rst_src: assert property ($rose(gain_control_soft_reset) |->
    $past(wr_b, 2) && $past(byte_data[0], 2))
    else $error("gain reset rose without bit 0");
  a_clk48_gate: assert property ($fell(clk48_run) |->
    $past(wr_b, 2) && $past(byte_data[3], 2))
    else $error("48 MHz run fell without bit 3");
  a_rec_gate: assert property ($fell(rec_clk_run) |->
    $past(wr_b, 2) && $past(byte_data[2], 2))
    else $error("receiver run fell without bit 2");
  a_rd_cause: assert property (rd_valid |-> $past(rd_req) && regs_armed)
    else $error("read data without armed request");
endmodule : ctl_top_asserts

bind clock_reset_control_top ctl_top_asserts u_chk (.*);

// ### tb/tb_top.sv
// Purpose: self-checking bench for the control-top block
// Assumes: slow free-running source clocks
// Notes: byte channel driven through the host model
`timescale 1ns/1ns
// ==================================================
// bench
module tb_top;
  logic clk;
  logic sys_rst;
  logic adc_src_clk;
  logic pll_src_clk;
  logic xfer_start, byte_valid, byte_on_reg_addr, rd_req, rd_valid, adc_clk, regs_armed;
  logic clk48_run, rec_clk_run, usb_protocol_block_rst, audio_if_rst, gain_control_soft_reset;
  logic pll_pwr_off, adc_l_pwr_off, adc_r_pwr_off, agc_l_pwr_off, agc_r_pwr_off;
  logic [7:0] byte_data, rd_data, d;
  logic [1:0] pll_rate_sel;
  logic v;
  int errors, check_count, cyc;

  clock_reset_control_top DUT (.*);
  uc_host_model host (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // sources of 8 and 12 system cycles
  initial begin
    pll_src_clk = 1'b0;
    forever #200 pll_src_clk = ~pll_src_clk;
  end
  initial begin
    adc_src_clk = 1'b0;
    forever #300 adc_src_clk = ~adc_src_clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] ctl();
    return {clk48_run, rec_clk_run, pll_rate_sel, usb_protocol_block_rst, audio_if_rst,
      gain_control_soft_reset, regs_armed};
  endfunction : ctl
  function automatic logic [7:0] pwr();
    return {3'h0, pll_pwr_off, adc_l_pwr_off, adc_r_pwr_off, agc_l_pwr_off, agc_r_pwr_off};
  endfunction : pwr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (3) @(posedge clk);
    #3;
  endtask : settle
  // cycles between two rising edges of adc_clk, 0 if none
  task automatic per(output logic [7:0] n);
    int r;
    logic p;
    r = 0;
    n = 8'h00;
    p = adc_clk;
    for (int k = 0; k < 300 && r < 2; k++) begin
      @(posedge clk);
      #3;
      if (r == 1) n++;
      if (adc_clk && !p) r++;
      p = adc_clk;
    end
  endtask : per
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  task automatic t_idle();
    chk(ctl(), 8'hC0);
    host.wr(8'h09, 8'h0B);
    settle();
    chk(ctl(), 8'hC0);
    host.rd(v, d);
    chk({7'h00, v}, 8'h00);
    $display("test idle done");
  endtask : t_idle
  task automatic t_regs();
    logic [7:0] exp [4] = '{8'hEE, 8'hCB, 8'h00, 8'h2F};
    host.arm();
    settle();
    chk({7'h00, regs_armed}, 8'h01);
    host.put(1'b1, 1'b1, 8'h08);
    repeat (4) host.put(1'b0, 1'b1, 8'hFF);
    settle();
    chk(ctl(), 8'h0F);
    chk(pwr(), 8'h1F);
    host.put(1'b1, 1'b1, 8'h08);
    for (int i = 0; i < 4; i++) begin
      host.rd(v, d);
      chk({7'h00, v}, 8'h01);
      chk(d, exp[i]);
    end
    $display("test regs done");
  endtask : t_regs
  task automatic t_codes();
    logic [7:0] rb [3] = '{8'h08, 8'h02, 8'h01};
    for (int c = 0; c < 4; c++) begin
      host.wr(8'h09, 8'(c << 6));
      settle();
      chk({6'h00, pll_rate_sel}, (c == 3) ? 8'h00 : 8'(c));
    end
    for (int i = 0; i < 3; i++) begin
      host.wr(8'h09, rb[i]);
      settle();
      chk(ctl() & 8'h0E, 8'h08 >> i);
    end
    $display("test codes done");
  endtask : t_codes
  task automatic t_adc();
    logic [7:0] n;
    for (int s = 0; s < 2; s++) begin
      for (int k = 0; k < 4; k++) begin
        host.wr(8'h08, 8'((s << 7) | (k << 5)));
        per(n);
        per(n);
        chk(n, 8'((s == 1 ? 12 : 8) << k));
      end
    end
    host.wr(8'h08, 8'h02);
    per(n);
    chk(n, 8'h00);
    host.wr(8'h08, 8'h08);
    settle();
    chk({6'h00, clk48_run, rec_clk_run}, 8'h01);
    host.wr(8'h08, 8'h04);
    settle();
    chk({6'h00, clk48_run, rec_clk_run}, 8'h02);
    $display("test adc done");
  endtask : t_adc
  task automatic t_disarm();
    host.put(1'b1, 1'b0, 8'h5A);
    settle();
    chk({7'h00, regs_armed}, 8'h00);
    host.wr(8'h09, 8'h08);
    settle();
    chk({7'h00, usb_protocol_block_rst}, 8'h00);
    host.rd(v, d);
    chk({7'h00, v}, 8'h00);
    $display("test disarm done");
  endtask : t_disarm
  task automatic t_midreset();
    host.arm();
    host.wr(8'h09, 8'h0B);
    settle();
    chk(ctl(), 8'h8F);
    host.put(1'b0, 1'b0, 8'hE8);
    host.put(1'b0, 1'b1, 8'h09);
    host.put(1'b0, 1'b1, 8'h01);
    settle();
    chk(ctl(), 8'h83);
    @(posedge clk);
    #2;
    sys_rst = 1'b1;
    @(posedge clk);
    #2;
    sys_rst = 1'b0;
    settle();
    chk(ctl(), 8'hC0);
    chk(pwr(), 8'h00);
    $display("test midreset done");
  endtask : t_midreset

  initial begin
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    t_idle();
    t_regs();
    t_codes();
    t_adc();
    t_disarm();
    t_midreset();
    report_and_stop();
  end
endmodule : tb_top

// ### tb/uc_host_model.sv
// Purpose: controller model driving the byte channel
// Assumes: bytes arrive already framed by the serial slave
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ns
// ==================================================
// model
module uc_host_model (
  // clock
  input wire logic clk,
  // byte channel
  output logic xfer_start,
  output logic byte_valid,
  output logic byte_on_reg_addr,
  output logic [7:0] byte_data,
  output logic rd_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  initial begin
    xfer_start = 1'b0;
    byte_valid = 1'b0;
    byte_on_reg_addr = 1'b0;
    byte_data = 8'hA5;
    rd_req = 1'b0;
  end
  task automatic put(input logic st, input logic ra, input logic [7:0] b);
    @(posedge clk);
    #2;
    xfer_start = st;
    byte_on_reg_addr = ra;
    byte_valid = 1'b1;
    byte_data = b;
    @(posedge clk);
    #2;
    xfer_start = 1'b0;
    byte_valid = 1'b0;
    byte_data = ~b;
  endtask : put
  task automatic arm();
    put(1'b1, 1'b0, 8'hE8);
  endtask : arm
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, 1'b1, a);
    put(1'b0, 1'b1, d);
  endtask : wr
  task automatic rd(output logic v, output logic [7:0] d);
    @(posedge clk);
    #2;
    rd_req = 1'b1;
    @(posedge clk);
    #2;
    rd_req = 1'b0;
    v = rd_valid;
    d = rd_data;
  endtask : rd
endmodule : uc_host_model
